// ==== core/hvac_pkg.sv ====
// shared constants and types of the wall controller logic
package hvac_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 40;
  localparam int NS_PER_S = 1_000_000_000;
  localparam int CYC_PER_S = NS_PER_S / CLK_PERIOD_NS;
  localparam int HOLD_S = 5;
  localparam int FLASH_S = 8;
  localparam int SWITCH_MIN = 15;
  localparam int SWITCH_S = SWITCH_MIN * 60;
  localparam int HOUR_S = 3600;
  // temperatures in whole degrees
  localparam logic [7:0] SET_MIN = 8'h11;
  localparam logic [7:0] SET_MAX = 8'h1e;
  localparam logic [7:0] SET_DEF = 8'h18;
  localparam logic signed [7:0] FROST_ON = 8'sh0a;
  localparam logic signed [7:0] FROST_OFF = 8'sh0f;
  localparam logic [7:0] PANEL_FROST = 8'h11;
  localparam logic [2:0] BAND_MIN = 3'h1;
  localparam logic [2:0] BAND_MAX = 3'h4;
  localparam logic [2:0] BAND_DEF = 3'h3;
  // filter reminder presets, in hours
  localparam logic [2:0] PRESET_MAX = 3'h4;
  localparam logic [2:0] PRESET_DEF = 3'h2;
  localparam logic [13:0] PRESET_HRS [5] = '{14'h0000, 14'h04e2, 14'h09c4, 14'h1388, 14'h2710};
  localparam logic [13:0] HOURS_SAT = 14'h3fff;
  // key inputs
  localparam int KEY_ONOFF = 0;
  localparam int KEY_MODE = 1;
  localparam int KEY_UP = 2;
  localparam int KEY_DOWN = 3;
  localparam int KEY_SWING = 4;
  localparam int KEY_FROST = 5;
  localparam int KEY_LOCK = 6;
  localparam int KEY_RESTR = 7;
  localparam int KEY_RESET = 8;
  localparam int KEY_CHECK = 9;
  localparam int KEY_OK = 10;
  localparam int KEY_CLOCK = 11;
  localparam int KEY_NUM = 12;
  localparam logic [11:0] KEYS_FREE = 12'h140;
  // fault codes: letter nibble and digit nibble
  localparam int FAULT_NUM = 10;
  localparam logic [7:0] FAULT_CODES [10] = '{8'he0, 8'he1, 8'he2, 8'he3, 8'he4,
                                              8'hed, 8'hef, 8'hf2, 8'hf3, 8'hf4};
  localparam logic [7:0] CODE_F1 = 8'hf1;
  // register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_SETTING = 8'h04;
  localparam logic [7:0] REG_HOURS = 8'h08;
  localparam logic [7:0] REG_REMOTE = 8'h0c;
  localparam logic [7:0] REG_FAULT = 8'h10;
  typedef enum logic [2:0] {MODE_AUTO, MODE_COOL, MODE_DRY, MODE_HEAT, MODE_FAN} mode_t;
  typedef enum logic [1:0] {RES_NONE, RES_COOL, RES_HEAT} restrict_t;
  typedef enum logic [1:0] {SETUP_NONE, SETUP_BAND, SETUP_FILTER} setup_t;
  typedef enum logic [1:0] {RUN_OFF, RUN_COOL, RUN_HEAT, RUN_FAN} run_t;
endpackage

// ==== core/hvac_ctrl.sv ====
// wall controller logic with AHB-Lite status and remote-command registers
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] setpoint keys act in auto/cool/dry/heat, 17..30
// [R2] swing key toggles swing while fan runs
// [R3] frost key enters; key or on/off exits, off
// [R4] frost: below 10 heat, led on, panel 17
// [R5] frost: above 15 stop heating, led off
// [R6] lock key toggles settings freeze
// [R7] restriction cycles none, cool-only, heat-only
// [R8] cool-only: mode cycles cool, dry, fan
// [R9] heat-only: heat is only mode
// [R10] reset key restarts, keeps settings
// [R11] three-pipe auto shows its own icon
// [R12] auto heats above band, cools below band
// [R13] auto changeover at most every 15 minutes
// [R14] band default 3, range 1..4, 5s entry
// [R15] other terminals cannot change auto mode
// [R16] two-pipe auto cools, fan forced auto
// [R17] filter due flashes F1 8s, again each power-on
// [R18] check plus ok clears reminder and hours
// [R19] check plus clock 5s: preset codes 0..4
// [R20] show two-character fault codes
// [R21] board switch picks two or three pipes
// [R22] mode cycle auto, cool, dry, heat, fan
// [R23] setpoint and band saturate at limits
// [R24] lock blocks all setting keys but lock
module hvac_ctrl #(
  parameter int SEC_CYCLES = hvac_pkg::CYC_PER_S
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [11:0] keys_i,
  input wire logic pipe_system_switch_i,
  input wire logic fan_running_i,
  input wire logic unit_running_i,
  input wire logic [9:0] faults_i,
  input wire logic signed [7:0] room_temp_i,
  output hvac_pkg::run_t run_mode_o,
  output hvac_pkg::mode_t mode_o,
  output logic [7:0] setpoint_temp_o,
  output logic power_o,
  output logic swing_o,
  output logic op_led_o,
  output logic frost_icon_o,
  output logic lock_icon_o,
  output logic three_pipe_icon_o,
  output logic fan_auto_forced_o,
  output logic [7:0] panel_code_o,
  output logic [7:0] fault_code_o
);
  import hvac_pkg::*;

  typedef struct packed {
    logic [11:0] kmeta;
    logic [11:0] ksync;
    logic [11:0] kprev;
    logic [3:0] pmeta;
    logic [3:0] psync;
    logic [9:0] emeta;
    logic [9:0] esync;
    logic power;
    logic frost;
    logic fheat;
    logic swing;
    logic lock;
    mode_t mode;
    restrict_t restr;
    logic [7:0] setp;
    logic [2:0] band;
    logic [2:0] preset;
    setup_t setup;
    logic act_heat;
    logic [9:0] swtmr;
    logic [31:0] seccnt;
    logic [2:0] hold_b;
    logic [2:0] hold_f;
    logic [11:0] hsec;
    logic [13:0] hours;
    logic due;
    logic [3:0] flash;
    logic prev_power;
    logic [2:0] remote;
    run_t run;
    logic [7:0] fcode;
    logic a_valid;
    logic a_write;
    logic [7:0] a_addr;
    logic [31:0] rdata;
  } state_t;

  state_t q;
  state_t d;
  logic [11:0] rise;
  logic [11:0] k;
  logic sec_tick;
  logic hour_evt;
  logic reach;
  logic two_pipe;
  logic signed [8:0] diff;
  logic signed [8:0] band_s;
  logic rem_wr;
  mode_t rem_mode;

  function automatic logic mode_ok(mode_t m, restrict_t r);
    case (r)
      RES_HEAT: mode_ok = (m == MODE_HEAT);
      RES_COOL: mode_ok = (m == MODE_COOL) || (m == MODE_DRY) || (m == MODE_FAN);
      default: mode_ok = 1'b1;
    endcase
  endfunction

  function automatic mode_t mode_next(mode_t m, restrict_t r);
    mode_next = MODE_AUTO;
    case (r)
      RES_HEAT: mode_next = MODE_HEAT;
      RES_COOL: begin
        case (m)
          MODE_COOL: mode_next = MODE_DRY;
          MODE_DRY: mode_next = MODE_FAN;
          default: mode_next = MODE_COOL;
        endcase
      end
      default: begin
        case (m)
          MODE_AUTO: mode_next = MODE_COOL;
          MODE_COOL: mode_next = MODE_DRY;
          MODE_DRY: mode_next = MODE_HEAT;
          MODE_HEAT: mode_next = MODE_FAN;
          default: mode_next = MODE_AUTO;
        endcase
      end
    endcase
  endfunction

  function automatic restrict_t restr_next(restrict_t r);
    case (r)
      RES_NONE: restr_next = RES_COOL;
      RES_COOL: restr_next = RES_HEAT;
      default: restr_next = RES_NONE;
    endcase
  endfunction

  always_comb begin
    d = q;
    // two-flop synchronisers for the key, pipe switch, fan, unit and fault pins
    d.kmeta = keys_i;
    d.ksync = q.kmeta;
    d.kprev = q.ksync;
    d.pmeta = {pipe_system_switch_i, fan_running_i, unit_running_i, 1'b0};
    d.psync = q.pmeta;
    d.emeta = faults_i;
    d.esync = q.emeta;
    rise = q.ksync & ~q.kprev;
    k = q.lock ? (rise & KEYS_FREE) : rise; // see [R24]
    two_pipe = q.psync[3]; // see [R21]
    sec_tick = (q.seccnt == 32'(SEC_CYCLES - 1));
    d.seccnt = sec_tick ? 32'h0 : q.seccnt + 32'h1;

    // bus: address phase, then write in data phase
    rem_wr = q.a_valid && q.a_write && (q.a_addr == REG_REMOTE);
    rem_mode = mode_t'(hwdata_i[2:0]);
    d.a_valid = hsel_i && htrans_i[1] && hready_i;
    d.a_write = hwrite_i;
    d.a_addr = haddr_i;
    d.rdata = 32'h0;
    if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
      case (haddr_i)
        REG_STATUS: d.rdata = {8'h00, q.setp, q.setup, two_pipe, (q.flash != 4'h0), q.due,
                               q.act_heat, q.lock, q.swing, q.fheat, q.frost, q.power, q.restr, q.mode};
        REG_SETTING: d.rdata = {25'h0, q.preset, 1'b0, q.band};
        REG_HOURS: d.rdata = {18'h0, q.hours};
        REG_REMOTE: d.rdata = {29'h0, q.remote};
        REG_FAULT: d.rdata = {23'h0, (q.fcode != 8'h00), q.fcode};
        default: d.rdata = 32'h0;
      endcase
    end
    if (rem_wr) begin
      d.remote = hwdata_i[2:0];
      if (!q.lock && q.mode != MODE_AUTO && !q.frost && hwdata_i[2:0] <= 3'h4
          && mode_ok(rem_mode, q.restr)) begin // see [R15]
        d.mode = rem_mode;
      end
    end

    // power and frost protection
    if (k[KEY_ONOFF]) begin
      if (q.frost) begin // see [R3]
        d.frost = 1'b0;
        d.power = 1'b0;
      end else begin
        d.power = !q.power;
      end
    end
    if (k[KEY_FROST]) begin
      d.frost = !q.frost; // see [R3]
      d.power = !q.frost;
    end
    if (!d.frost) begin
      d.fheat = 1'b0;
    end else if (room_temp_i < FROST_ON) begin
      d.fheat = 1'b1; // see [R4]
    end else if (room_temp_i > FROST_OFF) begin
      d.fheat = 1'b0; // see [R5]
    end

    // swing, lock, restriction, mode
    if (k[KEY_SWING] && q.psync[2]) begin
      d.swing = !q.swing; // see [R2]
    end
    if (k[KEY_LOCK]) begin
      d.lock = !q.lock; // see [R6]
    end
    if (k[KEY_RESTR]) begin
      d.restr = restr_next(q.restr); // see [R7]
      if (!mode_ok(d.mode, d.restr)) begin
        d.mode = (d.restr == RES_HEAT) ? MODE_HEAT : MODE_COOL; // see [R8] [R9]
      end
    end
    if (k[KEY_MODE] && !q.frost) begin
      d.mode = mode_next(d.mode, d.restr); // see [R22] [R8] [R9]
    end

    // arrows: setpoint, band or preset
    case (q.setup)
      SETUP_BAND: begin
        if (k[KEY_UP] && q.band < BAND_MAX) d.band = q.band + 3'h1; // see [R14] [R23]
        if (k[KEY_DOWN] && q.band > BAND_MIN) d.band = q.band - 3'h1; // see [R14] [R23]
        if (k[KEY_OK]) d.setup = SETUP_NONE;
      end
      SETUP_FILTER: begin
        if (k[KEY_UP] && q.preset < PRESET_MAX) d.preset = q.preset + 3'h1; // see [R19]
        if (k[KEY_DOWN] && q.preset != 3'h0) d.preset = q.preset - 3'h1; // see [R19]
        if (k[KEY_OK]) d.setup = SETUP_NONE;
      end
      default: begin
        if (!q.frost && q.mode != MODE_FAN) begin
          if (k[KEY_UP] && q.setp < SET_MAX) d.setp = q.setp + 8'h01; // see [R1] [R23]
          if (k[KEY_DOWN] && q.setp > SET_MIN) d.setp = q.setp - 8'h01; // see [R1] [R23]
        end
      end
    endcase

    // five-second two-key holds enter setup
    if (q.lock || !(q.ksync[KEY_UP] && q.ksync[KEY_DOWN])) begin
      d.hold_b = 3'h0;
    end else if (sec_tick && q.hold_b != 3'(HOLD_S)) begin
      d.hold_b = q.hold_b + 3'h1;
      if (q.hold_b == 3'(HOLD_S - 1) && q.setup == SETUP_NONE) d.setup = SETUP_BAND; // see [R14]
    end
    if (q.lock || !(q.ksync[KEY_CHECK] && q.ksync[KEY_CLOCK])) begin
      d.hold_f = 3'h0;
    end else if (sec_tick && q.hold_f != 3'(HOLD_S)) begin
      d.hold_f = q.hold_f + 3'h1;
      if (q.hold_f == 3'(HOLD_S - 1) && q.setup == SETUP_NONE) d.setup = SETUP_FILTER; // see [R19]
    end

    // automatic changeover, three-pipe only
    diff = $signed({1'b0, q.setp}) - $signed({room_temp_i[7], room_temp_i});
    band_s = $signed({6'h00, q.band});
    if (sec_tick && q.swtmr != 10'(SWITCH_S)) d.swtmr = q.swtmr + 10'h001;
    if (q.power && !q.frost && q.mode == MODE_AUTO && !two_pipe && q.swtmr == 10'(SWITCH_S)) begin // see [R13]
      if (!q.act_heat && diff > band_s) begin
        d.act_heat = 1'b1; // see [R12]
        d.swtmr = 10'h000;
      end else if (q.act_heat && diff < band_s) begin
        d.act_heat = 1'b0; // see [R12]
        d.swtmr = 10'h000;
      end
    end

    // filter run-time accumulator and reminder
    hour_evt = 1'b0;
    if (sec_tick && q.psync[1]) begin
      d.hsec = q.hsec + 12'h001;
      if (q.hsec == 12'(HOUR_S - 1)) begin
        d.hsec = 12'h000;
        hour_evt = 1'b1;
        if (q.hours != HOURS_SAT) d.hours = q.hours + 14'h0001;
      end
    end
    reach = hour_evt && q.preset != 3'h0 && (d.hours >= PRESET_HRS[q.preset]); // see [R19]
    if (q.flash != 4'h0 && sec_tick) d.flash = q.flash - 4'h1;
    if (k[KEY_CHECK] || k[KEY_OK]) begin
      if (q.ksync[KEY_CHECK] && q.ksync[KEY_OK]) begin
        d.hours = 14'h0000; // see [R18]
        d.hsec = 12'h000;
        d.due = 1'b0;
        d.flash = 4'h0;
      end
    end
    d.prev_power = d.power;
    if ((reach && !q.due) || (d.power && !q.prev_power && (q.due || reach))) begin
      d.flash = 4'(FLASH_S); // see [R17]
    end
    if (reach) d.due = 1'b1;

    // hidden reset: restart timers, keep settings
    if (k[KEY_RESET]) begin
      d.setup = SETUP_NONE; // see [R10]
      d.hold_b = 3'h0;
      d.hold_f = 3'h0;
      d.seccnt = 32'h0;
      d.swtmr = 10'(SWITCH_S);
      d.flash = 4'h0;
    end

    // command to the indoor unit
    if (q.frost) begin
      d.run = q.fheat ? RUN_HEAT : RUN_OFF;
    end else if (!q.power) begin
      d.run = RUN_OFF;
    end else begin
      case (q.mode)
        MODE_AUTO: d.run = (two_pipe || !q.act_heat) ? RUN_COOL : RUN_HEAT; // see [R16] [R21]
        MODE_HEAT: d.run = RUN_HEAT;
        MODE_FAN: d.run = RUN_FAN;
        default: d.run = RUN_COOL;
      endcase
    end

    // fault display, lowest index wins
    d.fcode = (q.flash != 4'h0) ? CODE_F1 : 8'h00; // see [R17]
    for (int i = FAULT_NUM - 1; i >= 0; i--) begin
      if (q.esync[i]) d.fcode = FAULT_CODES[i]; // see [R20]
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.setp <= SET_DEF;
      q.band <= BAND_DEF;
      q.preset <= PRESET_DEF;
      q.swtmr <= 10'(SWITCH_S);
    end else begin
      q <= d;
    end
  end

  assign hrdata_o = q.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign run_mode_o = q.run;
  assign mode_o = q.mode;
  assign setpoint_temp_o = q.setp;
  assign power_o = q.power;
  assign swing_o = q.swing;
  assign op_led_o = q.frost ? q.fheat : q.power; // see [R4] [R5]
  assign frost_icon_o = q.frost; // see [R3]
  assign lock_icon_o = q.lock;
  assign three_pipe_icon_o = q.power && !q.frost && q.mode == MODE_AUTO && !two_pipe; // see [R11]
  assign fan_auto_forced_o = q.power && !q.frost && q.mode == MODE_AUTO && two_pipe; // see [R16]
  assign panel_code_o = (q.frost && q.fheat) ? PANEL_FROST : 8'h00; // see [R4]
  assign fault_code_o = q.fcode;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_setp_range: assert property (q.setp >= SET_MIN && q.setp <= SET_MAX) // see [R1] [R23]
    else $error("setpoint outside range");
  chk_swing_needs_fan: assert property ($changed(q.swing) |-> $past(q.psync[2]) && $past(k[KEY_SWING])) // see [R2]
    else $error("swing changed without fan or key");
  chk_frost_exit_off: assert property (q.frost && (k[KEY_FROST] || k[KEY_ONOFF]) |=> !q.frost && !q.power) // see [R3]
    else $error("frost exit did not switch off");
  chk_frost_heat_on: assert property (q.frost && room_temp_i < FROST_ON && k == 12'h000
                                      |=> q.fheat && op_led_o && panel_code_o == PANEL_FROST) // see [R4]
    else $error("frost heating not started");
  chk_frost_heat_off: assert property (q.frost && room_temp_i > FROST_OFF |=> !q.fheat ##0 !op_led_o) // see [R5]
    else $error("frost heating not stopped");
  chk_lock_toggle: assert property (rise[KEY_LOCK] |=> q.lock != $past(q.lock)) // see [R6]
    else $error("lock did not toggle");
  chk_restrict_cycle: assert property (k[KEY_RESTR] |=> q.restr == restr_next($past(q.restr))) // see [R7]
    else $error("restriction order wrong");
  chk_restrict_modes: assert property (mode_ok(q.mode, q.restr)) // see [R8] [R9]
    else $error("mode not allowed by restriction");
  chk_switch_spacing: assert property ($changed(q.act_heat) |-> $past(q.swtmr) == 10'(SWITCH_S)) // see [R13]
    else $error("changeover too soon");
  chk_band_range: assert property (q.band >= BAND_MIN && q.band <= BAND_MAX) // see [R14] [R23]
    else $error("band outside range");
  chk_auto_kept: assert property (q.mode == MODE_AUTO && rem_wr && !k[KEY_MODE] && !k[KEY_RESTR] // see [R15]
                                  |=> q.mode == MODE_AUTO)
    else $error("remote changed auto mode");
  chk_lock_freeze: assert property (q.lock && !rem_wr ##1 q.lock |-> $stable(q.setp) && $stable(q.mode)) // see [R24]
    else $error("setting changed while locked");
  chk_f1_length: assert property ($rose(q.flash != 4'h0) |-> q.flash == 4'(FLASH_S)) // see [R17]
    else $error("reminder flash length wrong");

  cov_frost_heat: cover property (q.frost ##1 q.fheat);
  cov_auto_switch: cover property ($rose(q.act_heat));
  cov_filter_flash: cover property ($rose(q.flash != 4'h0));
  cov_locked_key: cover property (q.lock && rise[KEY_UP]);
endmodule // hvac_ctrl
`default_nettype wire

// ==== testbench/hvac_unit_model.sv ====
// behavioural indoor unit facing the wall controller
`timescale 1ns/1ps
`default_nettype none
module hvac_unit_model (
  input wire logic clock_i,
  input wire logic power_i,
  output logic fan_running_o,
  output logic unit_running_o
);
  // fan and unit follow the power command one cycle late
  always_ff @(posedge clock_i) begin
    fan_running_o <= power_i;
    unit_running_o <= power_i;
  end
endmodule // hvac_unit_model
`default_nettype wire

// ==== testbench/hvac_ctrl_tb_top.sv ====
// self-checking bench of the wall controller logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module hvac_ctrl_tb_top;
  import hvac_pkg::*;
  localparam int SEC = 10;
  logic clock_i, sys_rst_i, hsel, hwrite, pipe_sw, hreadyout, hresp, fan_run, unit_run;
  logic power, swing, op_led, frost_icon, lock_icon, tp_icon, fan_forced;
  logic [7:0] haddr, setpoint, panel, fcode;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, d;
  logic [11:0] keys;
  logic [9:0] faults;
  logic signed [7:0] room;
  run_t run_mode;
  mode_t mode, exp_m;
  mode_t cyc5 [5] = '{MODE_COOL, MODE_DRY, MODE_HEAT, MODE_FAN, MODE_AUTO};
  int n_mismatch = 0;
  int compares = 0;
  int ticks = 0;
  int n;

  hvac_ctrl #(.SEC_CYCLES(SEC)) hvac_ctrl_inst (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .keys_i(keys), .pipe_system_switch_i(pipe_sw), .fan_running_i(fan_run),
    .unit_running_i(unit_run), .faults_i(faults), .room_temp_i(room),
    .run_mode_o(run_mode), .mode_o(mode), .setpoint_temp_o(setpoint), .power_o(power),
    .swing_o(swing), .op_led_o(op_led), .frost_icon_o(frost_icon), .lock_icon_o(lock_icon),
    .three_pipe_icon_o(tp_icon), .fan_auto_forced_o(fan_forced), .panel_code_o(panel),
    .fault_code_o(fcode)
  );
  hvac_unit_model hvac_unit_model_inst (
    .clock_i(clock_i), .power_i(power), .fan_running_o(fan_run), .unit_running_o(unit_run)
  );

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    ticks <= ticks + 1;
    if (ticks == 70000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  task automatic hold(input logic [11:0] m, input int k);
    keys <= m;
    cyc(k);
    keys <= 12'h000;
    cyc(6);
  endtask
  task automatic press(input int k);
    hold(12'h001 << k, 6);
  endtask
  // one single-word transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    d = hrdata;
    `CHK("response", 1'b0, hresp)
  endtask

  initial begin
    sys_rst_i = 1'b1;
    keys = 12'h000;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    pipe_sw = 1'b0;
    faults = 10'h000;
    room = 8'sd20;
    cyc(16);
    sys_rst_i <= 1'b0;
    cyc(2);
    `CHK("setpoint", SET_DEF, setpoint)
    `CHK("mode", MODE_AUTO, mode)
    xfer(1'b0, REG_SETTING, 32'h0);
    `CHK("band", BAND_DEF, d[2:0])
    `CHK("preset", PRESET_DEF, d[6:4])
    xfer(1'b0, 8'h14, 32'h0);
    `CHK("unmapped", 32'h0, d)
    $display("test reset done");
    press(KEY_ONOFF);
    repeat (8) press(KEY_UP);
    `CHK("set max", SET_MAX, setpoint)
    repeat (14) press(KEY_DOWN);
    `CHK("set min", SET_MIN, setpoint)
    repeat (7) press(KEY_UP);
    for (int i = 0; i < 5; i++) begin
      press(KEY_MODE);
      `CHK("mode cycle", cyc5[i], mode)
      press(KEY_UP);
      `CHK("set by mode", (cyc5[i] == MODE_FAN) ? SET_DEF : SET_DEF + 8'h01, setpoint)
      press(KEY_DOWN);
    end
    $display("test setpoint and mode done");
    press(KEY_RESTR);
    xfer(1'b0, REG_STATUS, 32'h0);
    `CHK("cool only", 2'h1, d[4:3])
    exp_m = MODE_COOL;
    for (int i = 0; i < 5; i++) begin
      exp_m = (exp_m == MODE_COOL) ? MODE_DRY : (exp_m == MODE_DRY) ? MODE_FAN : MODE_COOL;
      press(KEY_MODE);
      `CHK("cool cycle", exp_m, mode)
    end
    press(KEY_RESTR);
    press(KEY_MODE);
    `CHK("heat only", MODE_HEAT, mode)
    press(KEY_MODE);
    `CHK("heat stays", MODE_HEAT, mode)
    press(KEY_RESTR);
    xfer(1'b0, REG_STATUS, 32'h0);
    `CHK("unrestricted", 2'h0, d[4:3])
    press(KEY_MODE);
    press(KEY_MODE);
    `CHK("back to auto", MODE_AUTO, mode)
    $display("test restriction done");
    press(KEY_SWING);
    `CHK("swing on", 1'b1, swing)
    press(KEY_SWING);
    `CHK("swing off", 1'b0, swing)
    press(KEY_ONOFF);
    press(KEY_SWING);
    `CHK("swing fan stopped", 1'b0, swing)
    press(KEY_ONOFF);
    press(KEY_LOCK);
    `CHK("lock icon", 1'b1, lock_icon)
    press(KEY_UP);
    press(KEY_MODE);
    `CHK("locked set", SET_DEF, setpoint)
    `CHK("locked mode", MODE_AUTO, mode)
    press(KEY_LOCK);
    `CHK("unlocked", 1'b0, lock_icon)
    xfer(1'b1, REG_REMOTE, {29'h0, MODE_COOL});
    cyc(2);
    `CHK("remote in auto", MODE_AUTO, mode)
    press(KEY_MODE);
    xfer(1'b1, REG_REMOTE, {29'h0, MODE_DRY});
    cyc(2);
    `CHK("remote in cool", MODE_DRY, mode)
    repeat (3) press(KEY_MODE);
    $display("test swing lock remote done");
    for (int e = 0; e < 2; e++) begin
      room <= 8'sd20;
      press(KEY_FROST);
      `CHK("frost icon", 1'b1, frost_icon)
      room <= 8'sd9;
      cyc(3);
      `CHK("frost heat", RUN_HEAT, run_mode)
      `CHK("frost led", 1'b1, op_led)
      `CHK("panel 17", PANEL_FROST, panel)
      room <= 8'sd15;
      cyc(3);
      `CHK("hysteresis", 1'b1, op_led)
      room <= 8'sd16;
      cyc(3);
      `CHK("frost stop", 1'b0, op_led)
      `CHK("panel clear", 8'h00, panel)
      press((e == 0) ? KEY_FROST : KEY_ONOFF);
      `CHK("frost exit", 2'h0, {frost_icon, power})
    end
    $display("test frost done");
    room <= 8'sd20;
    press(KEY_ONOFF);
    press(KEY_RESET);
    `CHK("kept set", SET_DEF, setpoint)
    `CHK("kept power", 1'b1, power)
    `CHK("three pipe icon", 1'b1, tp_icon)
    `CHK("auto heat", RUN_HEAT, run_mode)
    room <= 8'sd28;
    cyc(4);
    `CHK("auto cool", RUN_COOL, run_mode)
    room <= 8'sd20;
    cyc(800 * SEC);
    `CHK("min interval", RUN_COOL, run_mode)
    n = 0;
    while (run_mode !== RUN_HEAT && n < 200 * SEC) begin
      cyc(1);
      n++;
    end
    `CHK("changeover due", RUN_HEAT, run_mode)
    pipe_sw <= 1'b1;
    cyc(5);
    `CHK("two pipe cool", RUN_COOL, run_mode)
    `CHK("fan forced", 2'h1, {tp_icon, fan_forced})
    pipe_sw <= 1'b0;
    $display("test auto done");
    hold(12'h00c, 7 * SEC);
    xfer(1'b0, REG_STATUS, 32'h0);
    `CHK("band setup", 2'h1, d[15:14])
    repeat (2) press(KEY_UP);
    press(KEY_OK);
    xfer(1'b0, REG_SETTING, 32'h0);
    `CHK("band max", BAND_MAX, d[2:0])
    hold(12'ha00, 7 * SEC);
    xfer(1'b0, REG_STATUS, 32'h0);
    `CHK("filter setup", 2'h2, d[15:14])
    repeat (3) press(KEY_DOWN);
    press(KEY_UP);
    press(KEY_OK);
    xfer(1'b0, REG_SETTING, 32'h0);
    `CHK("preset code", 3'h1, d[6:4])
    // let the unit run until the first hour is counted
    n = 0;
    do begin
      cyc(10 * SEC);
      xfer(1'b0, REG_HOURS, 32'h0);
      n++;
    end while (d[13:0] == 14'h0 && n < 400);
    `CHK("hours run", 14'h1, d[13:0])
    keys <= 12'h200;
    cyc(6);
    keys <= 12'h600;
    cyc(6);
    keys <= 12'h000;
    cyc(6);
    xfer(1'b0, REG_HOURS, 32'h0);
    `CHK("hours cleared", 14'h0, d[13:0])
    $display("test setup done");
    for (int k = 0; k < FAULT_NUM; k++) begin
      faults <= 10'h001 << k;
      cyc(5);
      `CHK("fault code", FAULT_CODES[k], fcode)
    end
    faults <= 10'h000;
    cyc(5);
    `CHK("no fault", 8'h00, fcode)
    $display("test faults done");
    results();
  end
endmodule // hvac_ctrl_tb_top
`default_nettype wire
